// File: src/code_fault_timer.sv
// delayed reset request for a code held illegal for a number of cycles
`timescale 1ns/1ns
module code_fault_timer
    import rstgen_pkg::*;
#(
    parameter int CYCLES = 2
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic bad_i,
    output logic      fire_o
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    assign cnt_d  = !bad_i ? 4'h0 : (cnt_q == 4'(CYCLES)) ? cnt_q : cnt_q + 4'h1;
    assign fire_o = bad_i && (cnt_q == 4'(CYCLES));

    always_ff @(posedge clk_i) begin
        if (!nrst_i) cnt_q <= 4'h0;
        else         cnt_q <= cnt_d;
    end
endmodule : code_fault_timer

// File: src/reset_cause_ctrl.sv
// reset source logic: undervoltage, code guards, watchdog, cause flags, release delay
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// (RULE1) guard code reset sets guard fault flag
// (RULE2) undervoltage reset only after qualification time
// (RULE3) qualified undervoltage reset sets event flag
// (RULE4) four valid level codes select trip
// (RULE5) illegal level code resets after cycles
// (RULE6) illegal level code restores level to 0x55
// (RULE7) real undervoltage reset keeps level register
// (RULE8) undervoltage reset disabled in power-down
// (RULE9) illegal level code sets its fault flag
// (RULE10) cause register upper four bits read zero
// (RULE11) normal watchdog timeout full reset, sets timeout
// (RULE12) sleep timeout clears only pc, sp
// (RULE13) timeout and power-down flag update table
// (RULE14) power-on clears core units, ports input
// (RULE15) power-on or undervoltage release delay 50 ms
// (RULE16) normal watchdog release delay 16.7 ms
// (RULE17) guard codes 0x55/0xAA nop, else reset
// (RULE18) illegal watchdog enable code sets its flag
// (RULE19) all sources one reset, flags before release
module reset_cause_ctrl
    import rstgen_pkg::*;
#(
    parameter int POR_CYC  = POR_DELAY_CYC,
    parameter int WDOG_CYC = WDOG_DELAY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        low_supply_i,
    input  wire logic        powerdown_i,
    input  wire logic        sleep_idle_i,
    input  wire logic        wdog_timeout_i,
    output logic [1:0]       uv_trip_sel_o,
    output logic             wdog_enable_o,
    output logic [2:0]       wdog_period_o,
    output logic             core_reset_o,
    output logic             pc_sp_clear_o,
    output logic             irq_o
);
    bus_req_t   req;
    logic       ack_q;
    logic [7:0] level_q, guard_q, wdctl_q;
    logic [3:0] cause_q;
    logic       to_q, pdf_q;
    logic [3:0] irq_stat_q, irq_en_q;
    logic [7:0] rdata_q;
    logic [1:0] kind_q;
    logic [31:0] hold_q;
    logic [3:0] uv_cnt_q;
    logic       pcsp_q;

    assign req = '{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i[7:0]};
    // one wait state: the access completes on the second edge after it is presented
    assign avs_waitrequest_o = (req.read || req.write) && !ack_q;
    wire acc   = (req.read || req.write) && ack_q;
    wire wr    = acc && req.write;
    wire wr_lv = wr && req.address == ADDR_LEVEL;
    wire wr_gd = wr && req.address == ADDR_GUARD;
    wire wr_wd = wr && req.address == ADDR_WDCTL;
    wire wr_cs = wr && req.address == ADDR_CAUSE;
    wire wr_st = wr && req.address == ADDR_STATUS;
    wire wr_ie = wr && req.address == ADDR_IRQ_EN;
    wire wr_ic = wr && req.address == ADDR_IRQ_CLR;

    // code checks
    wire level_ok = level_q == UV_CODE_2V10 || level_q == UV_CODE_2V55 ||
                    level_q == UV_CODE_3V15 || level_q == UV_CODE_3V80;  // [RULE4]
    wire guard_ok = guard_q == GUARD_NOP_A || guard_q == GUARD_NOP_B;    // [RULE17]
    wire wd_ok    = wdctl_q[7:3] == WD_EN_OFF || wdctl_q[7:3] == WD_EN_ON;
    wire in_reset = kind_q != CAUSE_NONE;
    wire lv_fire, gd_fire, wd_fire;

    code_fault_timer #(.CYCLES(CODE_FAULT_CYCLES)) u_lv_timer (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .bad_i  (!level_ok && !in_reset),
        .fire_o (lv_fire)
    );  // [RULE5]
    code_fault_timer #(.CYCLES(CODE_FAULT_CYCLES)) u_gd_timer (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .bad_i  (!guard_ok && !in_reset),
        .fire_o (gd_fire)
    );  // [RULE17]
    code_fault_timer #(.CYCLES(CODE_FAULT_CYCLES)) u_wd_timer (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .bad_i  (!wd_ok && !in_reset),
        .fire_o (wd_fire)
    );

    // undervoltage qualification, off during power-down
    wire uv_low  = low_supply_i && !powerdown_i;  // [RULE8]
    wire uv_fire = uv_low && uv_cnt_q == 4'(UV_QUALIFY_CYCLES) && !in_reset;  // [RULE2]
    wire wd_norm = wdog_timeout_i && !sleep_idle_i && !in_reset;  // [RULE11]
    wire wd_slp  = wdog_timeout_i && sleep_idle_i && !in_reset;   // [RULE12]
    wire full_rst = uv_fire || lv_fire || gd_fire || wd_fire || wd_norm;  // [RULE19]
    wire [3:0] ev  = {gd_fire, uv_fire, lv_fire, wd_fire};
    wire [1:0] sts = {to_q, pdf_q};

    assign uv_trip_sel_o = level_q == UV_CODE_2V55 ? 2'd1 :
                           level_q == UV_CODE_3V15 ? 2'd2 :
                           level_q == UV_CODE_3V80 ? 2'd3 : 2'd0;
    assign wdog_enable_o = wdctl_q[7:3] == WD_EN_ON;
    assign wdog_period_o = wdctl_q[2:0];
    assign core_reset_o  = in_reset;  // [RULE14]
    assign pc_sp_clear_o = pcsp_q;
    assign irq_o         = |(irq_stat_q & irq_en_q);
    assign avs_readdata_o = {24'h0, rdata_q};

    wire [7:0] rd_mux =
        req.address == ADDR_LEVEL    ? level_q :
        req.address == ADDR_GUARD    ? guard_q :
        req.address == ADDR_WDCTL    ? wdctl_q :
        req.address == ADDR_CAUSE    ? {4'h0, cause_q} :  // [RULE10]
        req.address == ADDR_STATUS   ? {6'h0, sts} :
        req.address == ADDR_IRQ_STAT ? {4'h0, irq_stat_q} :
        req.address == ADDR_IRQ_EN   ? {4'h0, irq_en_q} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q   <= avs_waitrequest_o;
            rdata_q <= avs_waitrequest_o ? rd_mux : rdata_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) uv_cnt_q <= 4'h0;
        else if (!uv_low) uv_cnt_q <= 4'h0;  // [RULE2]
        else if (uv_cnt_q != 4'(UV_QUALIFY_CYCLES)) uv_cnt_q <= uv_cnt_q + 4'h1;
    end

    // control registers: code faults restore power-on codes, guard and watchdog control kept if undervoltage fires too; real undervoltage keeps level
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            level_q <= LEVEL_RESET;
            guard_q <= GUARD_RESET;
            wdctl_q <= WDCTL_RESET;
        end else begin
            if (lv_fire)    level_q <= LEVEL_RESET;  // [RULE6]
            else if (wr_lv) level_q <= req.writedata;  // [RULE7]
            if (full_rst && !uv_fire) guard_q <= GUARD_RESET;
            else if (wr_gd)           guard_q <= req.writedata;
            if (full_rst && !uv_fire) wdctl_q <= WDCTL_RESET;
            else if (wr_wd)           wdctl_q <= req.writedata;
        end
    end

    // cause flags: hardware set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cause_q <= 4'h0;
        end else begin
            cause_q <= (wr_cs ? (cause_q & req.writedata[3:0]) : cause_q) | ev;  // [RULE1] [RULE3] [RULE9] [RULE18]
        end
    end

    // timeout / power-down flags
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            to_q  <= 1'b0;  // [RULE13]
            pdf_q <= 1'b0;
        end else begin
            to_q  <= (wr_st ? req.writedata[STAT_TO_BIT] & to_q : to_q) | wd_norm | wd_slp;
            pdf_q <= (wr_st ? req.writedata[STAT_PDF_BIT] & pdf_q : pdf_q) | wd_slp;  // [RULE13]
        end
    end

    // internal reset hold with release delay; flags already written at entry
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            kind_q <= CAUSE_FULL;
            hold_q <= 32'(POR_CYC);  // [RULE15]
            pcsp_q <= 1'b0;
        end else begin
            pcsp_q <= wd_slp;  // [RULE12]
            if (full_rst) begin
                kind_q <= CAUSE_FULL;
                hold_q <= wd_norm && !(uv_fire || lv_fire || gd_fire || wd_fire) ?
                          32'(WDOG_CYC) : 32'(POR_CYC);  // [RULE16] [RULE15]
            end else if (in_reset) begin
                hold_q <= hold_q - 32'h1;
                if (hold_q == 32'h1) kind_q <= CAUSE_NONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_stat_q <= 4'h0;
            irq_en_q   <= 4'h0;
        end else begin
            irq_stat_q <= (wr_ic ? irq_stat_q & ~req.writedata[3:0] : irq_stat_q) | ev;
            if (wr_ie) irq_en_q <= req.writedata[3:0];
        end
    end

    property p_uv_flag;
        @(posedge clk_i) disable iff (!nrst_i) uv_fire |=> cause_q[CAUSE_UVEVT_BIT];
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("uv flag not set"); // [RULE3]
    property p_lv_restore;
        @(posedge clk_i) disable iff (!nrst_i) lv_fire |=> level_q == LEVEL_RESET && cause_q[1];
    endproperty
    a_lv_restore: assert property (p_lv_restore) else $error("level not restored"); // [RULE6]
    property p_lv_delay;
        @(posedge clk_i) disable iff (!nrst_i)
            $fell(level_ok) && !in_reset ##1 !level_ok [*2] |=> core_reset_o;
    endproperty
    a_lv_delay: assert property (p_lv_delay) else $error("late code fault reset"); // [RULE5]
    property p_guard;
        @(posedge clk_i) disable iff (!nrst_i) gd_fire |=> cause_q[3] && core_reset_o;
    endproperty
    a_guard: assert property (p_guard) else $error("guard fault lost"); // [RULE1]
    // watch the bus port itself, so a wrong mux or a missing zero fill shows
    property p_upper;
        @(posedge clk_i) disable iff (!nrst_i)
            avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_CAUSE
            |=> avs_readdata_o[31:4] == 28'h000_0000;
    endproperty
    a_upper: assert property (p_upper) else $error("cause upper bits set"); // [RULE10]
    property p_pd;
        @(posedge clk_i) disable iff (!nrst_i) powerdown_i |-> !uv_fire;
    endproperty
    a_pd: assert property (p_pd) else $error("uv reset in powerdown"); // [RULE8]
    property p_short;
        @(posedge clk_i) disable iff (!nrst_i) $rose(uv_low) |-> !uv_fire [*3];
    endproperty
    a_short: assert property (p_short) else $error("uv reset too early"); // [RULE2]
    property p_slp;
        @(posedge clk_i) disable iff (!nrst_i)
            wd_slp |=> to_q && pdf_q && pc_sp_clear_o && !core_reset_o;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep timeout wrong"); // [RULE12]
    property p_norm;
        @(posedge clk_i) disable iff (!nrst_i) wd_norm |=> to_q && core_reset_o;
    endproperty
    a_norm: assert property (p_norm) else $error("normal timeout wrong"); // [RULE11]

    // guard code held illegal: reset on the third cycle, as for the level code
    property p_guard_delay;
        @(posedge clk_i) disable iff (!nrst_i)
            $fell(guard_ok) && !in_reset ##1 !guard_ok [*2]
            |=> core_reset_o;
    endproperty
    a_guard_delay: assert property (p_guard_delay) else $error("late guard reset"); // [RULE17]

    // watchdog enable field held illegal: same delay as the other code guards
    property p_wd_delay;
        @(posedge clk_i) disable iff (!nrst_i)
            $fell(wd_ok) && !in_reset ##1 !wd_ok [*2]
            |=> core_reset_o;
    endproperty
    a_wd_delay: assert property (p_wd_delay) else $error("late watchdog code reset"); // [RULE18]

    property p_wd_flag;
        @(posedge clk_i) disable iff (!nrst_i)
            wd_fire |=> cause_q[CAUSE_WDOG_BIT] && core_reset_o;
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog code flag lost"); // [RULE18]

    property p_lv_flag;
        @(posedge clk_i) disable iff (!nrst_i)
            lv_fire |=> cause_q[CAUSE_UVCODE_BIT] && core_reset_o;
    endproperty
    a_lv_flag: assert property (p_lv_flag) else $error("level code flag lost"); // [RULE9]

    // cause bits never drop by themselves; only a bus write may clear them
    property p_cause_sticky;
        @(posedge clk_i) disable iff (!nrst_i)
            !wr_cs |=> (cause_q & $past(cause_q)) == $past(cause_q);
    endproperty
    a_cause_sticky: assert property (p_cause_sticky) else $error("cause bit lost"); // [RULE1]

    // a genuine low supply must not touch the selected trip level
    property p_uv_keep;
        @(posedge clk_i) disable iff (!nrst_i)
            uv_fire && !lv_fire && !wr_lv |=> level_q == $past(level_q);
    endproperty
    a_uv_keep: assert property (p_uv_keep) else $error("level changed by uv reset"); // [RULE7]

    property p_uv_status;
        @(posedge clk_i) disable iff (!nrst_i)
            uv_fire && !wd_norm && !wd_slp && !wr_st
            |=> to_q == $past(to_q) && pdf_q == $past(pdf_q);
    endproperty
    a_uv_status: assert property (p_uv_status) else $error("uv reset moved status"); // [RULE13]

    property p_norm_pdf;
        @(posedge clk_i) disable iff (!nrst_i)
            wd_norm && !wd_slp && !wr_st |=> pdf_q == $past(pdf_q);
    endproperty
    a_norm_pdf: assert property (p_norm_pdf) else $error("normal timeout set pdf"); // [RULE13]

    property p_por_hold;
        @(posedge clk_i) disable iff (!nrst_i)
            uv_fire |=> hold_q == 32'(POR_CYC) && core_reset_o;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("uv hold wrong"); // [RULE15]

    // the shorter watchdog delay only when nothing else asked for a reset
    property p_wd_hold;
        @(posedge clk_i) disable iff (!nrst_i)
            wd_norm && !(uv_fire || lv_fire || gd_fire || wd_fire)
            |=> hold_q == 32'(WDOG_CYC);
    endproperty
    a_wd_hold: assert property (p_wd_hold) else $error("watchdog hold wrong"); // [RULE16]

    property p_pcsp_src;
        @(posedge clk_i) disable iff (!nrst_i)
            pc_sp_clear_o |-> $past(wd_slp);
    endproperty
    a_pcsp_src: assert property (p_pcsp_src) else $error("stray pc sp clear"); // [RULE12]

    property p_trip_sel;
        @(posedge clk_i) disable iff (!nrst_i)
            level_q == UV_CODE_3V80 |-> uv_trip_sel_o == 2'd3;
    endproperty
    a_trip_sel: assert property (p_trip_sel) else $error("trip select wrong"); // [RULE4]

    // qualification restarts from zero whenever power-down masks the comparator
    property p_uv_off;
        @(posedge clk_i) disable iff (!nrst_i)
            powerdown_i |=> uv_cnt_q == 4'h0;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("uv counting in powerdown"); // [RULE8]

    // one wait state only: a held request is answered on the next edge
    property p_wait;
        @(posedge clk_i) disable iff (!nrst_i)
            avs_waitrequest_o |=> !avs_waitrequest_o || !(avs_read_i || avs_write_i);
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late"); // [RULE19]

    property p_irq_set;
        @(posedge clk_i) disable iff (!nrst_i)
            ev != 4'h0 |=> (irq_stat_q & $past(ev)) == $past(ev);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq status not set"); // [RULE19]

    c_uv:  cover property (@(posedge clk_i) disable iff (!nrst_i) uv_fire);
    c_lv:  cover property (@(posedge clk_i) disable iff (!nrst_i) lv_fire);
    c_slp: cover property (@(posedge clk_i) disable iff (!nrst_i) wd_slp);
    c_rel: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(core_reset_o));
endmodule : reset_cause_ctrl

// File: src/rstgen_pkg.sv
// package: register map, field layout, codes and timing of the reset generator
package rstgen_pkg;
    localparam logic [3:0] ADDR_LEVEL     = 4'h0;
    localparam logic [3:0] ADDR_GUARD     = 4'h1;
    localparam logic [3:0] ADDR_WDCTL     = 4'h2;
    localparam logic [3:0] ADDR_CAUSE     = 4'h3;
    localparam logic [3:0] ADDR_STATUS    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR   = 4'h7;

    localparam logic [7:0] UV_CODE_2V10   = 8'h55;
    localparam logic [7:0] UV_CODE_2V55   = 8'h33;
    localparam logic [7:0] UV_CODE_3V15   = 8'h99;
    localparam logic [7:0] UV_CODE_3V80   = 8'hAA;
    localparam logic [7:0] LEVEL_RESET    = 8'h55;
    localparam logic [7:0] GUARD_NOP_A    = 8'h55;
    localparam logic [7:0] GUARD_NOP_B    = 8'hAA;
    localparam logic [7:0] GUARD_RESET    = 8'h55;
    localparam logic [4:0] WD_EN_OFF      = 5'h15;
    localparam logic [4:0] WD_EN_ON       = 5'h0A;
    localparam logic [7:0] WDCTL_RESET    = 8'h53;

    localparam int CAUSE_WDOG_BIT         = 0;
    localparam int CAUSE_UVCODE_BIT       = 1;
    localparam int CAUSE_UVEVT_BIT        = 2;
    localparam int CAUSE_GUARD_BIT        = 3;
    localparam int STAT_PDF_BIT           = 0;
    localparam int STAT_TO_BIT            = 1;

    localparam int CLK_HZ                 = 10_000_000;
    localparam int CODE_FAULT_CYCLES      = 2;
    localparam int UV_QUALIFY_CYCLES      = 4;
    localparam int POR_DELAY_US           = 50_000;
    localparam int WDOG_DELAY_US          = 16_700;
    localparam int POR_DELAY_CYC  = (CLK_HZ / 1_000_000) * POR_DELAY_US;
    localparam int WDOG_DELAY_CYC = (CLK_HZ / 1_000_000) * WDOG_DELAY_US;

    typedef enum logic [1:0] {
        CAUSE_NONE  = 2'b00,
        CAUSE_FULL  = 2'b01,
        CAUSE_SOFT  = 2'b11
    } rst_kind_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [3:0] address;
        logic [7:0] writedata;
    } bus_req_t;
endpackage : rstgen_pkg

// File: tb/tb_reset_cause_ctrl.sv
// testbench: bus access, reset sources, cause flags and interrupt of the reset generator
`timescale 1ns/1ns
module tb_reset_cause_ctrl;
    import rstgen_pkg::*;
    localparam int POR_T = 20;
    localparam int WD_T  = 10;
    logic        clk_i, nrst_i, low_supply_i, powerdown_i, sleep_idle_i, wdog_timeout_i;
    bus_req_t    req;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o, wdog_enable_o, core_reset_o, pc_sp_clear_o, irq_o;
    logic [1:0]  uv_trip_sel_o;
    logic [2:0]  wdog_period_o;
    int          err_count, samples_checked, n;
    logic [7:0]  codes [4] = '{UV_CODE_2V10, UV_CODE_2V55, UV_CODE_3V15, UV_CODE_3V80};
    logic [3:0]  fa    [3] = '{ADDR_LEVEL, ADDR_GUARD, ADDR_WDCTL};
    logic [7:0]  fv    [3] = '{8'h12, 8'h00, 8'hFB};
    logic [7:0]  fc    [3] = '{8'h02, 8'h08, 8'h01};
    logic [7:0]  fr    [3] = '{LEVEL_RESET, GUARD_RESET, WDCTL_RESET};

    reset_cause_ctrl #(.POR_CYC(POR_T), .WDOG_CYC(WD_T)) reset_cause_ctrl_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(req.address),
        .avs_read_i(req.read), .avs_write_i(req.write),
        .avs_writedata_i({24'h0000_00, req.writedata}), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .low_supply_i(low_supply_i),
        .powerdown_i(powerdown_i), .sleep_idle_i(sleep_idle_i),
        .wdog_timeout_i(wdog_timeout_i), .uv_trip_sel_o(uv_trip_sel_o),
        .wdog_enable_o(wdog_enable_o), .wdog_period_o(wdog_period_o),
        .core_reset_o(core_reset_o), .pc_sp_clear_o(pc_sp_clear_o), .irq_o(irq_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8

    // request held until waitrequest is seen low at a rising edge, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int k;
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        q = avs_readdata_o[7:0];
        if (k >= 50) begin
            err_count++;
            $display("FAIL %0t bus answer timed out", $time);
            finish_test();
        end
        req <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check8(q, e, what);
    endtask : rchk

    task automatic wait_rst(input logic v, input int lim);
        n = 0;
        while (core_reset_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (core_reset_o !== v) begin
            err_count++;
            $display("FAIL %0t core reset wait timed out", $time);
            finish_test();
        end
    endtask : wait_rst

    task automatic dip(input int c);
        low_supply_i <= 1'b1;
        repeat (c) @(posedge clk_i);
        low_supply_i <= 1'b0;
    endtask : dip

    initial begin
        nrst_i = 1'b0;
        req = '0;
        low_supply_i = 1'b0;
        powerdown_i = 1'b0;
        sleep_idle_i = 1'b0;
        wdog_timeout_i = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        wait_rst(1'b0, POR_T + 5);
        check8(8'(n >= POR_T - 2 && n <= POR_T + 2), 8'h01, "power-on hold");
        check8({7'h0, wdog_enable_o}, 8'h01, "watchdog counting");
        check8({5'h0, wdog_period_o}, {5'h0, WDCTL_RESET[2:0]}, "wdog period");
        rchk(ADDR_LEVEL, LEVEL_RESET, "level reset value");
        rchk(ADDR_GUARD, GUARD_RESET, "guard reset value");
        rchk(ADDR_WDCTL, WDCTL_RESET, "wdctl reset value");
        rchk(ADDR_CAUSE, 8'h00, "cause reset value");
        rchk(ADDR_STATUS, 8'h00, "status reset value");
        wr(4'hA, 8'hFF);
        rchk(4'hA, 8'h00, "unmapped read");
        foreach (codes[i]) begin
            wr(ADDR_LEVEL, codes[i]);
            rchk(ADDR_LEVEL, codes[i], "level code");
            check8({6'h0, uv_trip_sel_o}, 8'(i), "trip select");
        end
        check8({7'h0, core_reset_o}, 8'h00, "valid codes no reset");
        // a dip one cycle shorter than UV_QUALIFY_CYCLES must pass unnoticed
        wr(ADDR_LEVEL, UV_CODE_3V15);
        dip(UV_QUALIFY_CYCLES - 1);
        repeat (4) @(posedge clk_i);
        check8({7'h0, core_reset_o}, 8'h00, "short dip");
        dip(UV_QUALIFY_CYCLES + 4);
        wait_rst(1'b1, 8);
        wait_rst(1'b0, POR_T + 5);
        check8(8'(n >= POR_T - 2 && n <= POR_T + 2), 8'h01, "uv hold");
        rchk(ADDR_CAUSE, 8'h04, "uv event flag");
        rchk(ADDR_LEVEL, UV_CODE_3V15, "level kept");
        rchk(ADDR_STATUS, 8'h00, "uv keeps status");
        wr(ADDR_CAUSE, 8'h00);
        rchk(ADDR_CAUSE, 8'h00, "cause cleared");
        wr(ADDR_GUARD, GUARD_NOP_B);
        repeat (5) @(posedge clk_i);
        check8({7'h0, core_reset_o}, 8'h00, "guard nop");
        wr(ADDR_IRQ_CLR, 8'h0F);
        wr(ADDR_IRQ_EN, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(fa[i], fv[i]);
            wait_rst(1'b1, 8);
            check8(8'(n >= 2 && n <= 4), 8'h01, "code fault delay");
            wait_rst(1'b0, POR_T + 5);
            rchk(ADDR_CAUSE, fc[i], "fault flag");
            rchk(fa[i], fr[i], "restored code");
            wr(ADDR_CAUSE, 8'h00);
        end
        rchk(ADDR_IRQ_STAT, 8'h0B, "irq status");
        check8({7'h0, irq_o}, 8'h00, "irq masked");
        wr(ADDR_IRQ_EN, 8'h08);
        check8({7'h0, irq_o}, 8'h01, "irq enabled");
        wr(ADDR_IRQ_CLR, 8'h08);
        check8({7'h0, irq_o}, 8'h00, "irq cleared");
        rchk(ADDR_IRQ_STAT, 8'h03, "irq status left");
        wdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdog_timeout_i <= 1'b0;
        wait_rst(1'b1, 5);
        wait_rst(1'b0, WD_T + 5);
        check8(8'(n >= WD_T - 2 && n <= WD_T + 2), 8'h01, "wdog hold");
        rchk(ADDR_STATUS, 8'h02, "timeout flag");
        wr(ADDR_STATUS, 8'h00);
        sleep_idle_i <= 1'b1;
        wdog_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdog_timeout_i <= 1'b0;
        n = 0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            n += int'(pc_sp_clear_o === 1'b1);
        end
        check8(8'(n), 8'h01, "pc sp clear pulse");
        check8({7'h0, core_reset_o}, 8'h00, "sleep no reset");
        rchk(ADDR_STATUS, 8'h03, "sleep flags");
        sleep_idle_i <= 1'b0;
        // power-down is last: it does not touch the status flags checked above
        powerdown_i <= 1'b1;
        dip(UV_QUALIFY_CYCLES + 4);
        repeat (4) @(posedge clk_i);
        check8({7'h0, core_reset_o}, 8'h00, "uv off in power-down");
        powerdown_i <= 1'b0;
        finish_test();
    end
endmodule : tb_reset_cause_ctrl
